// ==== src/wws_pkg.sv ====
// Package for the window watchdog supervisor: variants, timing, carriers.
// Assumes a 20 MHz system clock; filter, backup and voltage delays become cycle counts here.
package wws_pkg;
    localparam int CLK_HZ = 20_000_000;
    // Printed times in their own units
    localparam int KICK_REJECT_NS = 1000;
    localparam int KICK_ACCEPT_NS = 6500;
    localparam int BACKUP_DELAY_US = 100;
    localparam int VMON_DELAY_US = 1;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    // Filter: least width rounds up, accept bound rounds down
    localparam int FILT_CYC = (KICK_REJECT_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    localparam int FILT_MAX_CYC = KICK_ACCEPT_NS / CLK_PERIOD_NS;
    localparam int BACKUP_DLY_CYC = BACKUP_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int VMON_DLY_CYC = VMON_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int FIRST_MULT = 8;
    localparam int BAD_LIMIT = 3;
    localparam int GOOD_LIMIT = 3;
    localparam int WIN50_PCT = 50;
    localparam int WIN75_PCT = 75;
    localparam int PCT_FULL = 100;
    // Default periods: 12 ms kick timeout, 5 ms reset hold
    localparam int KICK_TIMEOUT_US = 12000;
    localparam int RESET_HOLD_US = 5000;
    localparam int CNT_W = 32;

    typedef enum logic [1:0] {
        WWS_MODE_TIMEOUT = 2'h0,
        WWS_MODE_WIN50 = 2'h1,
        WWS_MODE_WIN75 = 2'h2
    } wws_mode_t;

    typedef struct packed {
        logic reset_n;
        logic backup_n;
    } wws_out_t;
endpackage : wws_pkg

// ==== src/wws_supervisor.sv ====
// Window watchdog supervisor: kick filter, watchdog timer, reset hold
// timer and backup-enable logic.
// Assumes all level inputs are asynchronous pins; outputs are active low
// and meant to drive open-drain pads (low = driven, high = released).
//
// Summary of operation
// - Reset low on low monitored voltage or a kick timing fault.
// - Reset held low one hold period after every cause clears.
// - Gated variant: watchdog off while gate low, runs when gate high.
// - First period after gate rises lasts eight kick timeouts.
// - Timeout variants: kicks must come within timeout, else reset pulse.
// - Watchdog timer clears on each kick and while reset is asserted.
// - Window variants: too early or too late kick forces reset.
// - Window variants: timer idle in reset, counts from zero after.
// - Backup enable low after three timeouts with no kick.
// - Backup enable released after three good kicks in a row.
// - Backup enable never asserted while voltage or gate is low.
// - Kick pulses under 1 us rejected, over 6.5 us accepted.
// - Period setting tied low disables the whole watchdog.
// - Backup enable changes about 100 us after the third bad event.
// - Reset falls about 1 us after voltage drops below threshold.
// - Closed window is 50 or 75 percent of the kick timeout.
// - Kick edges ignored while reset output is low.
// - Gated: first kick ends the long period, normal periods follow.
`timescale 1ns/100ps
`default_nettype none
module wws_supervisor
    import wws_pkg::*;
#(
    parameter wws_mode_t MODE = WWS_MODE_TIMEOUT,
    parameter bit GATED = 1'b0,
    parameter int KICK_TIMEOUT_CYC =
        KICK_TIMEOUT_US * 1000 / CLK_PERIOD_NS,
    parameter int RESET_HOLD_CYC =
        RESET_HOLD_US * 1000 / CLK_PERIOD_NS
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic watchdog_kick_input_i,
    input wire logic monitored_voltage_input_i,
    input wire logic gate_input_i,
    input wire logic watchdog_period_setting_i,
    output logic reset_n_o,
    output logic backup_enable_n_o
);
    default clocking cb_sys @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] TMO = CNT_W'(KICK_TIMEOUT_CYC);
    localparam logic [CNT_W-1:0] TMO_LONG =
        CNT_W'(KICK_TIMEOUT_CYC * FIRST_MULT);
    localparam int WIN_PCT = (MODE == WWS_MODE_WIN75) ? WIN75_PCT :
                             (MODE == WWS_MODE_WIN50) ? WIN50_PCT : 0;
    localparam logic [CNT_W-1:0] CLOSED =
        CNT_W'(KICK_TIMEOUT_CYC / PCT_FULL * WIN_PCT);
    localparam logic [CNT_W-1:0] HOLD = CNT_W'(RESET_HOLD_CYC);
    localparam logic [7:0] FILT = 8'(FILT_CYC);
    localparam logic [11:0] BDLY = 12'(BACKUP_DLY_CYC);
    localparam logic [5:0] VDLY = 6'(VMON_DLY_CYC);
    localparam bit WINDOWED = (MODE != WWS_MODE_TIMEOUT);

    function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v);
        inc_sat = (v == '1) ? v : v + CNT_W'(1);
    endfunction : inc_sat

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] kick_s, vmon_s, gate_s, wpset_s;
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            // Kick pin idles high; a low start would mimic a kick edge
            kick_s <= 2'h3;
            vmon_s <= 2'h0;
            gate_s <= 2'h0;
            wpset_s <= 2'h0;
        end else begin
            kick_s <= {kick_s[0], watchdog_kick_input_i};
            vmon_s <= {vmon_s[0], monitored_voltage_input_i};
            gate_s <= {gate_s[0], gate_input_i};
            wpset_s <= {wpset_s[0], watchdog_period_setting_i};
        end
    end
    wire logic kick_sync = kick_s[1];
    wire logic vmon_ok = GATED ? 1'b1 : vmon_s[1];
    wire logic gate_ok = GATED ? gate_s[1] : 1'b1;
    wire logic wd_on = wpset_s[1] && gate_ok;

    // ------------------------------------------------------------
    // Kick pulse filter: level must hold FILT cycles to be taken
    // ------------------------------------------------------------
    logic kick_filt;
    logic [7:0] filt_cnt;
    logic kick_fall;
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            kick_filt <= 1'b1;
            filt_cnt <= 8'h00;
            kick_fall <= 1'b0;
        end else begin
            kick_fall <= 1'b0;
            if (kick_sync == kick_filt) begin
                filt_cnt <= 8'h00;
            end else if (filt_cnt == FILT - 8'h01) begin
                kick_filt <= kick_sync;
                filt_cnt <= 8'h00;
                kick_fall <= kick_filt;
            end else begin
                filt_cnt <= filt_cnt + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Monitored voltage delay to reset
    // ------------------------------------------------------------
    logic [5:0] vdly_cnt;
    logic vlow;
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            vdly_cnt <= 6'h00;
            vlow <= 1'b1;
        end else if (vmon_ok) begin
            vdly_cnt <= 6'h00;
            vlow <= 1'b0;
        end else if (vdly_cnt == VDLY - 6'h01) begin
            vlow <= 1'b1;
        end else begin
            vdly_cnt <= vdly_cnt + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // Watchdog timer and fault detection
    // ------------------------------------------------------------
    logic [CNT_W-1:0] wd_cnt;
    logic long_period;
    logic gate_prev;
    logic in_reset;
    // Kicks are seen only while reset is released
    wire logic kick_ok = kick_fall && !in_reset && wd_on;
    wire logic [CNT_W-1:0] limit = long_period ? TMO_LONG : TMO;
    wire logic expire = wd_on && !in_reset && (wd_cnt >= limit - CNT_W'(1));
    wire logic early = WINDOWED && kick_ok && (wd_cnt < CLOSED);
    wire logic wd_fault = !GATED && (expire || early);

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            wd_cnt <= '0;
        end else if (!wd_on || in_reset || kick_ok || expire) begin
            wd_cnt <= '0;
        end else begin
            wd_cnt <= inc_sat(wd_cnt);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            gate_prev <= 1'b0;
            long_period <= 1'b0;
        end else begin
            gate_prev <= gate_ok;
            if (GATED && gate_ok && !gate_prev) begin
                long_period <= 1'b1;
            end else if (kick_ok) begin
                long_period <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Reset hold timer
    // ------------------------------------------------------------
    logic [CNT_W-1:0] hold_cnt;
    logic wd_rst;
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            // Gated variant has no reset output, so it never holds one
            in_reset <= !GATED;
            hold_cnt <= '0;
            wd_rst <= 1'b0;
        end else if (vlow || wd_fault) begin
            in_reset <= !GATED;
            hold_cnt <= '0;
            wd_rst <= wd_fault;
        end else if (in_reset && !(wd_rst ? 1'b0 : vlow)) begin
            if (hold_cnt >= HOLD - CNT_W'(1)) begin
                in_reset <= 1'b0;
                wd_rst <= 1'b0;
            end else begin
                hold_cnt <= inc_sat(hold_cnt);
            end
        end
    end

    // ------------------------------------------------------------
    // Backup enable
    // ------------------------------------------------------------
    logic [1:0] bad_cnt, good_cnt;
    logic bk_pend;
    logic [11:0] bk_cnt;
    logic bk_on;
    wire logic blocked = !vmon_ok || !gate_ok;
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            bad_cnt <= 2'h0;
            good_cnt <= 2'h0;
            bk_pend <= 1'b0;
            bk_cnt <= 12'h000;
            bk_on <= 1'b0;
        end else begin
            if (kick_ok) begin
                bad_cnt <= 2'h0;
            end else if (expire && bad_cnt != 2'(BAD_LIMIT)) begin
                bad_cnt <= bad_cnt + 2'h1;
            end
            if (expire) begin
                good_cnt <= 2'h0;
            end else if (kick_ok && !early && bk_on) begin
                good_cnt <= (good_cnt == 2'(GOOD_LIMIT - 1)) ? 2'h0
                            : good_cnt + 2'h1;
            end
            if (blocked) begin
                bk_pend <= 1'b0;
                bk_on <= 1'b0;
            end else if (!bk_on && expire && bad_cnt == 2'(BAD_LIMIT - 1))
            begin
                bk_pend <= 1'b1;
                bk_cnt <= 12'h000;
            end else if (bk_pend) begin
                if (bk_cnt == BDLY - 12'h001) begin
                    bk_on <= 1'b1;
                    bk_pend <= 1'b0;
                end else begin
                    bk_cnt <= bk_cnt + 12'h001;
                end
            end else if (bk_on && kick_ok && !early
                         && good_cnt == 2'(GOOD_LIMIT - 1)) begin
                bk_on <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    wws_out_t outs;
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            outs <= '{reset_n: GATED, backup_n: 1'b1};
        end else begin
            outs.reset_n <= !in_reset;
            outs.backup_n <= !bk_on;
        end
    end
    assign reset_n_o = outs.reset_n;
    assign backup_enable_n_o = outs.backup_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_vlow_reset: assert property (
        (!GATED && vlow) |=> ##1 !reset_n_o)
        else $error("reset not low under low voltage");
    a_ignore_kick: assert property (
        (in_reset && kick_fall) |=> $stable(bad_cnt) && $stable(good_cnt))
        else $error("kick taken during reset");
    a_timer_idle: assert property (
        in_reset |=> wd_cnt == '0)
        else $error("timer ran in reset");
    a_backup_block: assert property (
        blocked |=> ##1 backup_enable_n_o)
        else $error("backup asserted while blocked");
    a_disable_wd: assert property (
        !wpset_s[1] |=> wd_cnt == '0 && $stable(bad_cnt))
        else $error("watchdog active while disabled");
    a_early_fault: assert property (
        (early && !GATED) |=> in_reset)
        else $error("early kick did not reset");
    a_kick_clear: assert property (
        (kick_ok && !expire) |=> wd_cnt == '0)
        else $error("kick did not clear timer");
    a_filter_min: assert property (
        $rose(kick_fall) |-> $past(kick_sync, 1) == 1'b0 && !kick_filt)
        else $error("kick edge not filtered");
endmodule : wws_supervisor
`default_nettype wire

// ==== bench/wws_kick_model.sv ====
// Behavioural microcontroller that toggles the watchdog kick pin.
// Assumes the bench sets period and low width in clock cycles.
`timescale 1ns/100ps
`default_nettype none
module wws_kick_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [15:0] period_i,
    input wire logic [15:0] width_i,
    output logic kick_o
);
    // ------------------------------------------------------------
    // Kick generator
    // ------------------------------------------------------------
    // Idle span first, then the low pulse. The idle span is read live, so
    // a shorter period acts at once; a held reset aborts it, so a reset
    // core restarts its kick schedule from scratch.
    int idle;
    initial kick_o = 1'b1;
    always begin
        @(posedge clk_i);
        #1;
        if (run_i && rst_n_i) begin
            idle = 0;
            while (idle < period_i - width_i && rst_n_i) begin
                @(posedge clk_i);
                #1;
                idle++;
            end
            if (rst_n_i) begin
                kick_o = 1'b0;
                repeat (width_i) @(posedge clk_i);
                #1 kick_o = 1'b1;
            end
        end
    end
endmodule : wws_kick_model
`default_nettype wire

// ==== bench/window_watchdog_supervisor_bench.sv ====
// Self-checking bench: one supervisor in the timeout variant and one in
// the 50 percent window variant, each kicked by its own model.
// Assumes short sim periods: 400-cycle kick timeout, 200-cycle hold.
`timescale 1ns/100ps
`default_nettype none
module window_watchdog_supervisor_bench;
    import wws_pkg::*;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic vmon = 1'b1;
    logic period_set = 1'b1;
    logic run = 1'b1;
    logic [15:0] period = 16'h00c8;
    logic [15:0] width = 16'h008c;
    logic kick;
    logic reset_n_o;
    logic backup_enable_n_o;
    logic run_w = 1'b1;
    logic [15:0] period_w = 16'h0168;
    logic [15:0] width_w = 16'h008c;
    logic kick_w;
    logic win_reset_n;
    logic win_backup_n;
    int fail_count = 0;
    int n_tests = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    // Kicks straight through reset, so ignored kicks get exercised
    wws_kick_model u_mcu (.clk_i(clk_sys_i), .rst_n_i(1'b1), .run_i(run),
        .period_i(period), .width_i(width), .kick_o(kick));

    // Core held by the window supervisor's reset output
    wws_kick_model u_mcu_win (.clk_i(clk_sys_i), .rst_n_i(win_reset_n),
        .run_i(run_w), .period_i(period_w), .width_i(width_w),
        .kick_o(kick_w));

    wws_supervisor #(.MODE(WWS_MODE_WIN50), .GATED(1'b0),
        .KICK_TIMEOUT_CYC(400), .RESET_HOLD_CYC(200)) u_dut_win (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .watchdog_kick_input_i(kick_w),
        .monitored_voltage_input_i(vmon), .gate_input_i(1'b1),
        .watchdog_period_setting_i(period_set), .reset_n_o(win_reset_n),
        .backup_enable_n_o(win_backup_n));

    wws_supervisor #(.MODE(WWS_MODE_TIMEOUT), .GATED(1'b0),
        .KICK_TIMEOUT_CYC(400), .RESET_HOLD_CYC(200)) u_dut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .watchdog_kick_input_i(kick),
        .monitored_voltage_input_i(vmon), .gate_input_i(1'b1),
        .watchdog_period_setting_i(period_set), .reset_n_o(reset_n_o),
        .backup_enable_n_o(backup_enable_n_o));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    task check(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : cyc

    // 0 reset, 1 backup, 2 window reset, else window backup
    function logic cur(input int sel);
        case (sel)
            0: return reset_n_o;
            1: return backup_enable_n_o;
            2: return win_reset_n;
            default: return win_backup_n;
        endcase
    endfunction : cur

    // Bounded wait for a level, then judge it
    task wait_out(input string nm, input int sel, input logic v, int mx);
        int i;
        for (i = 0; i < mx && cur(sel) !== v; i++) cyc(1);
        check(nm, {31'h0, cur(sel)}, {31'h0, v});
    endtask : wait_out

    // Level must hold on every cycle of the span
    task hold_out(input string nm, input int sel, input logic v, int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            cyc(1);
            if (cur(sel) !== v) bad = 1'b1;
        end
        check(nm, {31'h0, bad}, 32'h0000_0000);
    endtask : hold_out

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_power_up;
        check("reset in reset", {31'h0, reset_n_o}, 32'h0000_0000);
        hold_out("reset hold after start", 0, 1'b0, 150);
        wait_out("reset release", 0, 1'b1, 100);
    endtask : t_power_up

    task t_good_kicks;
        hold_out("reset with good kicks", 0, 1'b1, 2000);
        check("backup idle", {31'h0, cur(1)}, 32'h0000_0001);
    endtask : t_good_kicks

    // Window variant: kicks inside the open window pass, early or late
    // ones fault; after each release the timer restarts from zero
    task t_window;
        hold_out("window in-window kicks", 2, 1'b1, 800);
        period_w = 16'h0064;
        width_w = 16'h0028;
        wait_out("window early kick", 2, 1'b0, 600);
        period_w = 16'h0168;
        width_w = 16'h008c;
        wait_out("window early release", 2, 1'b1, 300);
        hold_out("window after release", 2, 1'b1, 800);
        run_w = 1'b0;
        wait_out("window late kick", 2, 1'b0, 900);
        run_w = 1'b1;
        wait_out("window late release", 2, 1'b1, 300);
        hold_out("window kicks resumed", 2, 1'b1, 800);
        check("win backup", {31'h0, cur(3)}, 32'h0000_0001);
    endtask : t_window

    task t_vmon_drop;
        vmon = 1'b0;
        run = 1'b0;
        wait_out("reset on low voltage", 0, 1'b0, 30);
        hold_out("backup with low voltage", 1, 1'b1, 3000);
        vmon = 1'b1;
        run = 1'b1;
        hold_out("reset hold after voltage", 0, 1'b0, 190);
        wait_out("reset after voltage", 0, 1'b1, 40);
    endtask : t_vmon_drop

    task t_lost_kicks;
        run = 1'b0;
        wait_out("reset on missed kick", 0, 1'b0, 700);
        hold_out("reset fault hold", 0, 1'b0, 180);
        wait_out("reset after fault", 0, 1'b1, 40);
        wait_out("backup after three", 1, 1'b0, 5000);
        run = 1'b1;
        hold_out("backup before three kicks", 1, 1'b0, 300);
        wait_out("backup release", 1, 1'b1, 2000);
        wait_out("reset with kicks", 0, 1'b1, 300);
    endtask : t_lost_kicks

    task t_narrow;
        width = 16'h000a;
        wait_out("reset on narrow kicks", 0, 1'b0, 700);
        width = 16'h008c;
        wait_out("reset after narrow", 0, 1'b1, 300);
        hold_out("reset wide kicks", 0, 1'b1, 600);
    endtask : t_narrow

    task t_disabled;
        period_set = 1'b0;
        run = 1'b0;
        hold_out("reset watchdog off", 0, 1'b1, 1500);
        check("backup wd off", {31'h0, cur(1)}, 32'h0000_0001);
    endtask : t_disabled

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        cyc(2);
        resetn_i = 1'b1;
        t_power_up();
        t_good_kicks();
        t_window();
        t_vmon_drop();
        t_lost_kicks();
        t_narrow();
        t_disabled();
        give_verdict();
    end

    // Runs well past the longest expected path of all scenarios
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        fail_count++;
        give_verdict();
    end
endmodule : window_watchdog_supervisor_bench
`default_nettype wire
